// ---- logic/bsdc_ctrl.sv ----
// bitslip and single-trip delay calibration control registers with consistency check
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
`include "bsdc_consts.svh"
`default_nettype none
module bsdc_ctrl
  import bsdc_pkg::*;
#(
  parameter bit          CAL_FEATURE = 1'b1,
  parameter int unsigned SLIP_W      = 5,
  parameter int unsigned DELAY_W     = 17
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire bsdc_wb_req_t       wbReq,
  output var  bsdc_wb_rsp_t       wbRsp,
  input  wire logic [SLIP_W-1:0]  rxAlignSlip,
  input  wire logic               xcvrResetting,
  input  wire logic               wordAlignActive,
  input  wire logic               commaShift,
  output var  logic [SLIP_W-1:0]  txSlipBits,
  input  wire logic               hyperframeStart,
  input  wire logic [DELAY_W-1:0] calCurrentDelay,
  output var  logic               calEnable,
  output var  logic               calModuleReset,
  output var  logic               phaseControlUnitReset,
  output var  logic               calRestart
);
  logic [SLIP_W-1:0] rxSlip_q;
  logic [SLIP_W-1:0] txSlip_q;
  logic              txSlipEn_q;
  logic              calEn_q;
  logic              calCheck_q;
  logic              calReset_q;
  logic [7:0]        cycleDelay_q;
  logic [8:0]        stepDelay_q;
  logic              calEnPrev_q;
  logic              checkDue_q;
  bsdc_chk_state_t   chk_q;
  logic              stretchRst;
  logic              wrStb;
  logic              rdStb;
  logic [31:0]       rdData;
  logic [DELAY_W-1:0] targetDelay;

  // single-cycle answer; ack drops the cycle after so a held request is not acked on two cycles in a row
  assign wrStb = wbReq.cyc && wbReq.stb && wbReq.we && !wbRsp.ack;
  assign rdStb = wbReq.cyc && wbReq.stb && !wbReq.we && !wbRsp.ack;

  // read mux, reserved fields and unmapped offsets return zero
  always_comb begin
    rdData = 32'h0000_0000;
    case (wbReq.adr)
      `BSDC_OFF_BITSLIP: begin
        rdData[`BSDC_RXSLIP_MSB:`BSDC_RXSLIP_LSB] = rxSlip_q;
        rdData[`BSDC_TXSLIP_EN_BIT]               = txSlipEn_q;
        rdData[`BSDC_TXSLIP_MSB:`BSDC_TXSLIP_LSB] = txSlip_q;
      end
      `BSDC_OFF_CALCTRL: begin
        if (CAL_FEATURE) begin
          rdData[`BSDC_CAL_RESET_BIT] = calReset_q;
          rdData[`BSDC_CAL_CHECK_BIT] = calCheck_q;
          rdData[`BSDC_CAL_EN_BIT]    = calEn_q;
        end
      end
      `BSDC_OFF_CALDELAY: begin
        if (CAL_FEATURE) begin
          rdData[`BSDC_STEP_MSB:`BSDC_STEP_LSB]   = stepDelay_q;
          rdData[`BSDC_CYCLE_MSB:`BSDC_CYCLE_LSB] = cycleDelay_q;
        end
      end
      default: rdData = 32'h0000_0000;
    endcase
  end

  // bus answer registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wbRsp <= '0;
    end else begin
      wbRsp.ack <= wrStb || rdStb;
      wbRsp.dat <= rdStb ? rdData : 32'h0000_0000;
    end
  end

  // bitslip register writes; byte lanes 0 holds both transmit fields
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txSlip_q   <= `BSDC_SLIP_RESET;
      txSlipEn_q <= 1'b0;
    end else if (wrStb && wbReq.adr == `BSDC_OFF_BITSLIP && wbReq.sel[0]) begin
      txSlip_q   <= wbReq.dat[`BSDC_TXSLIP_MSB:`BSDC_TXSLIP_LSB];
      txSlipEn_q <= wbReq.dat[`BSDC_TXSLIP_EN_BIT];
    end
  end

  // transmit slip follows the field only while manual updates are enabled; otherwise it holds
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txSlipBits <= `BSDC_SLIP_RESET;
    end else if (txSlipEn_q) begin
      txSlipBits <= txSlip_q;
    end
  end

  // receive slip captured only during sync with transceiver reset or a comma move while aligning
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxSlip_q <= `BSDC_SLIP_RESET;
    end else if (xcvrResetting || (wordAlignActive && commaShift)) begin
      rxSlip_q <= rxAlignSlip;
    end
  end

  // calibration control; the calibration reset never touches these bits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      calEn_q    <= 1'b0;
      calCheck_q <= 1'b0;
      calReset_q <= 1'b0;
    end else if (CAL_FEATURE && wrStb && wbReq.adr == `BSDC_OFF_CALCTRL) begin
      if (wbReq.sel[0]) calEn_q <= wbReq.dat[`BSDC_CAL_EN_BIT];
      if (wbReq.sel[1]) calCheck_q <= wbReq.dat[`BSDC_CAL_CHECK_BIT];
      if (wbReq.sel[2]) calReset_q <= wbReq.dat[`BSDC_CAL_RESET_BIT];
    end
  end

  // programmed target delay, whole cycles and step units
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cycleDelay_q <= `BSDC_CYCLE_RESET;
      stepDelay_q  <= `BSDC_STEP_RESET;
    end else if (CAL_FEATURE && wrStb && wbReq.adr == `BSDC_OFF_CALDELAY) begin
      if (wbReq.sel[0]) cycleDelay_q <= wbReq.dat[`BSDC_CYCLE_MSB:`BSDC_CYCLE_LSB];
      if (wbReq.sel[2]) stepDelay_q[7:0] <= wbReq.dat[23:16];
      if (wbReq.sel[3]) stepDelay_q[8] <= wbReq.dat[`BSDC_STEP_MSB];
    end
  end

  // the stretcher keeps the reset clean for both receivers even on a one-cycle pulse
  bsdc_reset_stretch #(
    .HOLD (`BSDC_CAL_RST_CYCLES)
  ) u_rst (
    .clk    (clk),
    .rst_n  (rst_n),
    .req    (calReset_q),
    .rstOut (stretchRst)
  );

  // both resets driven from flops; release follows the bit returning to zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      calModuleReset        <= 1'b0;
      phaseControlUnitReset <= 1'b0;
      calEnable             <= 1'b0;
    end else begin
      calModuleReset        <= calReset_q || stretchRst;
      phaseControlUnitReset <= calReset_q || stretchRst;
      calEnable             <= calEn_q && !calReset_q;
    end
  end

  // target as cycles in upper bits, steps below
  assign targetDelay = {cycleDelay_q, stepDelay_q};

  // schedule a check on each hyperframe when periodic, else on enable rising
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      calEnPrev_q <= 1'b0;
      checkDue_q  <= 1'b0;
    end else begin
      calEnPrev_q <= calEn_q;
      if (calReset_q) begin
        checkDue_q <= 1'b0;
      end else if (calCheck_q) begin
        checkDue_q <= calEn_q && hyperframeStart;
      end else begin
        checkDue_q <= calEn_q && !calEnPrev_q;
      end
    end
  end

  // compare then trigger a one-cycle restart pulse on mismatch
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chk_q      <= BSDC_IDLE;
      calRestart <= 1'b0;
    end else begin
      calRestart <= 1'b0;
      case (chk_q)
        BSDC_IDLE: begin
          if (checkDue_q && !calReset_q) chk_q <= BSDC_COMPARE;
        end
        BSDC_COMPARE: begin
          if (calReset_q) chk_q <= BSDC_IDLE;
          else if (targetDelay != calCurrentDelay) chk_q <= BSDC_RECAL;
          else chk_q <= BSDC_IDLE;
        end
        BSDC_RECAL: begin
          calRestart <= 1'b1;
          chk_q      <= BSDC_IDLE;
        end
        default: chk_q <= BSDC_IDLE;
      endcase
    end
  end

  a_ack_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    wbRsp.ack |=> !wbRsp.ack) else $error("ack held too long");
  a_ack_follows_req: assert property (@(posedge clk) disable iff (!rst_n)
    (wbReq.cyc && wbReq.stb && !wbRsp.ack) |=> wbRsp.ack) else $error("no ack");
  a_rx_slip_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(xcvrResetting) && !($past(wordAlignActive) && $past(commaShift)) |-> $stable(rxSlip_q))
    else $error("rx slip moved");
  a_rx_slip_load: assert property (@(posedge clk) disable iff (!rst_n)
    (wordAlignActive && commaShift) |=> rxSlip_q == $past(rxAlignSlip)) else $error("rx slip not loaded");
  a_tx_slip_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !txSlipEn_q |=> $stable(txSlipBits)) else $error("tx slip moved while disabled");
  a_tx_slip_apply: assert property (@(posedge clk) disable iff (!rst_n)
    txSlipEn_q |=> txSlipBits == $past(txSlip_q)) else $error("tx slip not applied");
  a_cal_reset_on: assert property (@(posedge clk) disable iff (!rst_n)
    calReset_q |=> calModuleReset && phaseControlUnitReset) else $error("cal reset missing");
  a_cal_reset_off: assert property (@(posedge clk) disable iff (!rst_n)
    !calReset_q [*4] |-> !calModuleReset && !phaseControlUnitReset) else $error("cal reset stuck");
  a_ctrl_kept: assert property (@(posedge clk) disable iff (!rst_n)
    (calReset_q && !wrStb) |=> $stable(calEn_q) && $stable(calCheck_q)) else $error("ctrl changed");
  a_check_blocked: assert property (@(posedge clk) disable iff (!rst_n)
    calReset_q |=> !checkDue_q) else $error("check during reset");
  a_mismatch_restart: assert property (@(posedge clk) disable iff (!rst_n)
    (chk_q == BSDC_COMPARE && !calReset_q && targetDelay != calCurrentDelay) |=> ##1 calRestart)
    else $error("no restart");
  a_enable_check: assert property (@(posedge clk) disable iff (!rst_n)
    (!calCheck_q && !calReset_q && calEn_q && !calEnPrev_q) |=> checkDue_q) else $error("no enable check");

  // bus side: data only rides with an answer and reserved positions never carry a one
  a_ack_data_zero: assert property (@(posedge clk) disable iff (!rst_n)
    !wbRsp.ack |-> wbRsp.dat == 32'h0000_0000)
    else $error("read data outside an answer");
  a_reserved_high: assert property (@(posedge clk) disable iff (!rst_n)
    wbRsp.dat[31:25] == 7'h00)
    else $error("upper reserved bits set");
  a_reserved_mid: assert property (@(posedge clk) disable iff (!rst_n)
    wbRsp.dat[15:9] == 7'h00)
    else $error("middle reserved bits set");
  a_slip_reserved: assert property (@(posedge clk) disable iff (!rst_n)
    (rdStb && wbReq.adr == `BSDC_OFF_BITSLIP) |=> wbRsp.dat[15:6] == 10'h000 && wbRsp.dat[31:21] == 11'h000)
    else $error("bitslip reserved bits set");
  a_unmapped_read: assert property (@(posedge clk) disable iff (!rst_n)
    (rdStb && wbReq.adr != `BSDC_OFF_BITSLIP && wbReq.adr != `BSDC_OFF_CALCTRL
      && wbReq.adr != `BSDC_OFF_CALDELAY) |=> wbRsp.dat == 32'h0000_0000)
    else $error("unmapped offset returned data");

  // register contents seen through the bus
  a_rx_slip_read: assert property (@(posedge clk) disable iff (!rst_n)
    (rdStb && wbReq.adr == `BSDC_OFF_BITSLIP) |=> wbRsp.dat[20:16] == $past(rxSlip_q))
    else $error("rx slip read wrong");
  a_ctrl_read: assert property (@(posedge clk) disable iff (!rst_n)
    (rdStb && wbReq.adr == `BSDC_OFF_CALCTRL) |=> wbRsp.dat[0] == (CAL_FEATURE && $past(calEn_q)))
    else $error("control read wrong");
  a_tx_field_write: assert property (@(posedge clk) disable iff (!rst_n)
    (wrStb && wbReq.adr == `BSDC_OFF_BITSLIP && wbReq.sel[0]) |=> txSlip_q == $past(wbReq.dat[4:0]))
    else $error("tx slip field not written");
  a_slip_en_write: assert property (@(posedge clk) disable iff (!rst_n)
    (wrStb && wbReq.adr == `BSDC_OFF_BITSLIP && wbReq.sel[0]) |=> txSlipEn_q == $past(wbReq.dat[5]))
    else $error("tx slip enable not written");
  a_cal_en_write: assert property (@(posedge clk) disable iff (!rst_n)
    (CAL_FEATURE && wrStb && wbReq.adr == `BSDC_OFF_CALCTRL && wbReq.sel[0])
    |=> calEn_q == $past(wbReq.dat[0]))
    else $error("enable bit not written");
  a_reset_write: assert property (@(posedge clk) disable iff (!rst_n)
    (CAL_FEATURE && wrStb && wbReq.adr == `BSDC_OFF_CALCTRL && wbReq.sel[2])
    |=> calReset_q == $past(wbReq.dat[16]))
    else $error("reset bit not written");
  a_cycle_write: assert property (@(posedge clk) disable iff (!rst_n)
    (CAL_FEATURE && wrStb && wbReq.adr == `BSDC_OFF_CALDELAY && wbReq.sel[0])
    |=> cycleDelay_q == $past(wbReq.dat[7:0]))
    else $error("cycle delay not written");
  a_step_write: assert property (@(posedge clk) disable iff (!rst_n)
    (CAL_FEATURE && wrStb && wbReq.adr == `BSDC_OFF_CALDELAY && wbReq.sel[2])
    |=> stepDelay_q[7:0] == $past(wbReq.dat[23:16]))
    else $error("step delay not written");

  // receive slip loads at sync as well as on a comma move
  a_sync_load: assert property (@(posedge clk) disable iff (!rst_n)
    xcvrResetting |=> rxSlip_q == $past(rxAlignSlip))
    else $error("rx slip not loaded at sync");

  // calibration outputs and the check sequencer
  a_enable_on: assert property (@(posedge clk) disable iff (!rst_n)
    (calEn_q && !calReset_q) |=> calEnable)
    else $error("calibration not enabled");
  a_enable_off: assert property (@(posedge clk) disable iff (!rst_n)
    (!calEn_q || calReset_q) |=> !calEnable)
    else $error("calibration left on");
  a_reset_pair: assert property (@(posedge clk) disable iff (!rst_n)
    calModuleReset == phaseControlUnitReset)
    else $error("reset outputs differ");
  a_reset_release: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(calReset_q) ##1 !calReset_q [*2] |=> !calModuleReset && !phaseControlUnitReset)
    else $error("reset not released");
  a_seq_idle: assert property (@(posedge clk) disable iff (!rst_n)
    calReset_q |=> chk_q == BSDC_IDLE)
    else $error("sequencer busy in reset");
  a_periodic_due: assert property (@(posedge clk) disable iff (!rst_n)
    (calCheck_q && calEn_q && !calReset_q && hyperframeStart) |=> checkDue_q)
    else $error("hyperframe check missed");
  a_periodic_only: assert property (@(posedge clk) disable iff (!rst_n)
    (calCheck_q && !calReset_q && !hyperframeStart) |=> !checkDue_q)
    else $error("check between hyperframes");
  a_due_compare: assert property (@(posedge clk) disable iff (!rst_n)
    (checkDue_q && !calReset_q && chk_q == BSDC_IDLE) |=> chk_q == BSDC_COMPARE)
    else $error("due check not compared");
  a_restart_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    calRestart |=> !calRestart)
    else $error("restart longer than a cycle");
  a_match_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (chk_q == BSDC_COMPARE && targetDelay == calCurrentDelay) |=> ##1 !calRestart)
    else $error("restart on a match");

  c_restart: cover property (@(posedge clk) disable iff (!rst_n) calRestart);
  c_periodic: cover property (@(posedge clk) disable iff (!rst_n) calCheck_q && checkDue_q);
  c_cal_reset: cover property (@(posedge clk) disable iff (!rst_n) $fell(calModuleReset));
  c_comma: cover property (@(posedge clk) disable iff (!rst_n) wordAlignActive && commaShift);
  c_enable_check: cover property (@(posedge clk) disable iff (!rst_n) !calCheck_q && checkDue_q);
endmodule : bsdc_ctrl
`default_nettype wire

// ---- logic/bsdc_consts.svh ----
// offsets, field positions, reset values and timing counts of the bitslip and calibration control bank
`ifndef BSDC_CONSTS_SVH
`define BSDC_CONSTS_SVH
`define BSDC_OFF_BITSLIP     8'h5c
`define BSDC_OFF_CALCTRL     8'h60
`define BSDC_OFF_CALDELAY    8'h64
`define BSDC_RXSLIP_LSB      16
`define BSDC_RXSLIP_MSB      20
`define BSDC_TXSLIP_LSB      0
`define BSDC_TXSLIP_MSB      4
`define BSDC_TXSLIP_EN_BIT   5
`define BSDC_CAL_EN_BIT      0
`define BSDC_CAL_CHECK_BIT   8
`define BSDC_CAL_RESET_BIT   16
`define BSDC_CYCLE_LSB       0
`define BSDC_CYCLE_MSB       7
`define BSDC_STEP_LSB        16
`define BSDC_STEP_MSB        24
`define BSDC_SLIP_RESET      5'h00
`define BSDC_CYCLE_RESET     8'h00
`define BSDC_STEP_RESET      9'h000
`define BSDC_CAL_RST_CYCLES  2
`endif

// ---- logic/bsdc_pkg.sv ----
// types shared by the bitslip and calibration control bank
package bsdc_pkg;
  // wishbone request from the bus master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } bsdc_wb_req_t;
  // wishbone answer to the bus master
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } bsdc_wb_rsp_t;
  // consistency check sequencer
  typedef enum logic [1:0] {
    BSDC_IDLE    = 2'b00,
    BSDC_COMPARE = 2'b01,
    BSDC_RECAL   = 2'b11
  } bsdc_chk_state_t;
endpackage : bsdc_pkg

// ---- logic/bsdc_reset_stretch.sv ----
// reset stretcher that holds the calibration reset for a minimum number of cycles
`timescale 1ns/1ps
`default_nettype none
module bsdc_reset_stretch #(
  parameter int unsigned HOLD = 2
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic req,
  output var  logic rstOut
);
  logic [3:0] cnt_q;
  // reload while requested, count down after release so both sides see a clean pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q  <= 4'h0;
      rstOut <= 1'b0;
    end else if (req) begin
      cnt_q  <= 4'(HOLD);
      rstOut <= 1'b1;
    end else if (cnt_q != 4'h0) begin
      cnt_q  <= cnt_q - 4'h1;
      rstOut <= (cnt_q != 4'h1);
    end else begin
      rstOut <= 1'b0;
    end
  end
endmodule : bsdc_reset_stretch
`default_nettype wire

// ---- dv/bsdc_link_model.sv ----
// far side model: transceiver aligner, hyperframe timing and phase control unit
`timescale 1ns/1ps
`default_nettype none
module bsdc_link_model #(
  parameter int unsigned HF = 16
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  slip,
  input  wire logic        sync,
  input  wire logic        comma,
  input  wire logic [16:0] dly,
  input  wire logic        pcuRst,
  output var  logic [4:0]  rxSlip,
  output var  logic        resetting,
  output var  logic        aligning,
  output var  logic        shift,
  output var  logic        hfStart,
  output var  logic [16:0] curDelay
);
  int cnt;
  // aligner lines follow the bench requests
  assign rxSlip = slip;
  assign resetting = sync;
  assign aligning = comma;
  assign shift = comma;
  // free running hyperframe pulse, one cycle wide
  always_ff @(posedge clk) begin
    cnt <= (!rst_n || cnt == HF - 1) ? 0 : cnt + 1;
    hfStart <= rst_n && cnt == HF - 1;
  end
  // a unit held in reset reports no valid delay, so show a wrong one
  assign curDelay = pcuRst ? ~dly : dly;
endmodule : bsdc_link_model
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for the bitslip and calibration control bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bsdc_pkg::*;
  localparam int HF = 16;
  logic         clk, rst_n, sync, comma, e;
  logic [4:0]   slip, v, rxExp, expTx, txS, rxS;
  logic [16:0]  dly, cur;
  logic [7:0]   cyc8;
  logic [8:0]   stp;
  logic [31:0]  q;
  logic         rs, al, sh, hf, calEn, modRst, pcuRst, restart;
  bsdc_wb_req_t req;
  bsdc_wb_rsp_t rsp;
  int           bad_count, checks_done, restarts, r0, seed;
  bsdc_ctrl DUT (.clk(clk), .rst_n(rst_n), .wbReq(req), .wbRsp(rsp), .rxAlignSlip(rxS),
    .xcvrResetting(rs), .wordAlignActive(al), .commaShift(sh), .txSlipBits(txS),
    .hyperframeStart(hf), .calCurrentDelay(cur), .calEnable(calEn), .calModuleReset(modRst),
    .phaseControlUnitReset(pcuRst), .calRestart(restart));
  bsdc_link_model #(.HF(HF)) link (.clk(clk), .rst_n(rst_n), .slip(slip), .sync(sync),
    .comma(comma), .dly(dly), .pcuRst(pcuRst), .rxSlip(rxS), .resetting(rs), .aligning(al),
    .shift(sh), .hfStart(hf), .curDelay(cur));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // counted on the falling edge so the main sequence never races it
  always @(negedge clk) if (restart === 1'b1) restarts++;
  function automatic logic [31:0] expSlip(logic [4:0] r, logic en, logic [4:0] t);
    return {11'h0, r, 10'h0, en, t};
  endfunction : expSlip
  function automatic logic [31:0] expTgt(logic [7:0] c, logic [8:0] s);
    return {7'h0, s, 8'h0, c};
  endfunction : expTgt
  task automatic idle(int n);
    repeat (n) @(posedge clk);
  endtask : idle
  // one classic cycle, held until ack is seen
  // waits for ack however long it takes; only the watchdog ends a hung cycle
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    req <= '{1'b1, 1'b1, w, 4'hf, a, d};
    do begin
      @(posedge clk);
    end while (rsp.ack !== 1'b1);
    q = rsp.dat;
    req <= '0;
    @(posedge clk);
  endtask : wb
  task automatic chkW(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t word %h exp %h", $time, got, exp);
    end
  endtask : chkW
  task automatic chkN(int got, int exp);
    checks_done++;
    if (got != exp) begin
      bad_count++;
      $display("[ERR] %0t count %0d exp %0d", $time, got, exp);
    end
  endtask : chkN
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  // watchdog sized well above the whole sequence
  initial begin
    idle(4000);
    bad_count++;
    wrap_up();
  end
  initial begin
    seed = 41761;
    rst_n = 1'b0;
    req = '0;
    {sync, comma, slip, dly, rxExp, expTx} = '0;
    idle(5);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, 8'h5c + 8'(4 * i), 32'h0);
      chkW(q, 32'h0);
    end
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      v = 5'($unsigned($random(seed)) % 20);
      e = i[0];
      wb(1'b1, 8'h5c, 32'hffff_ffc0 | {e, v});
      if (e) expTx = v;
      wb(1'b0, 8'h5c, 32'h0);
      chkW(q, expSlip(rxExp, e, v));
      chkW(32'(txS), 32'(expTx));
    end
    $display("test tx slip done");
    slip <= 5'($random(seed));
    idle(2);
    wb(1'b0, 8'h5c, 32'h0);
    chkW(q, expSlip(rxExp, e, v));
    for (int k = 0; k < 2; k++) begin
      slip <= 5'($random(seed));
      @(posedge clk);
      if (k == 0) sync <= 1'b1;
      else comma <= 1'b1;
      @(posedge clk);
      sync <= 1'b0;
      comma <= 1'b0;
      rxExp = slip;
      slip <= ~slip;
      wb(1'b0, 8'h5c, 32'h0);
      chkW(q, expSlip(rxExp, e, v));
    end
    $display("test rx slip done");
    cyc8 = 8'($random(seed));
    stp = 9'($random(seed));
    wb(1'b1, 8'h64, {7'h7f, stp, 8'hff, cyc8});
    wb(1'b0, 8'h64, 32'h0);
    chkW(q, expTgt(cyc8, stp));
    $display("test target delay done");
    // enable edges with checking off: two mismatches, then a match
    for (int k = 0; k < 3; k++) begin
      dly <= {cyc8, stp} ^ 17'(k < 2);
      r0 = restarts;
      wb(1'b1, 8'h60, 32'h1);
      chkW(32'(calEn), 32'h1);
      idle(30);
      chkN(restarts - r0, int'(k < 2));
      wb(1'b1, 8'h60, 32'h0);
      chkW(32'(calEn), 32'h0);
    end
    $display("test enable checks done");
    // periodic checking: mismatch, match, then under calibration reset
    for (int k = 0; k < 3; k++) begin
      dly <= {cyc8, stp} ^ 17'(k != 1);
      wb(1'b1, 8'h60, k == 2 ? 32'h1_0101 : 32'h101);
      idle(20);
      r0 = restarts;
      idle(HF * 5);
      chkN(restarts - r0, k == 0 ? 5 : 0);
    end
    $display("test periodic checks done");
    chkW({modRst, pcuRst, calEn}, 32'h6);
    wb(1'b0, 8'h64, 32'h0);
    chkW(q, expTgt(cyc8, stp));
    wb(1'b0, 8'h60, 32'h0);
    chkW(q, 32'h1_0101);
    wb(1'b1, 8'h60, 32'h101);
    idle(6);
    chkW({modRst, pcuRst, calEn}, 32'h1);
    $display("test calibration reset done");
    wrap_up();
  end
endmodule : tb
`default_nettype wire
